// ===== plc_far_side_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Pins and the two peripheral functions
module plc_far_side_model (
    input wire logic clk,
    input wire logic shuffle,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] pullup_en,
    output logic [31:0] pin_in,
    output logic [31:0] a_out,
    output logic [31:0] a_oe,
    output logic [31:0] b_out,
    output logic [31:0] b_oe
);
    logic [31:0] ext;
    initial begin
        {a_out, a_oe, b_out, b_oe, ext} = {5{32'h0}};
    end
    // New requests only on command, so the bench knows what it compares against
    always @(posedge clk) begin
        if (shuffle) begin
            a_out <= $urandom();
            a_oe <= $urandom();
            b_out <= $urandom();
            b_oe <= $urandom();
            ext <= $urandom();
        end
    end
    // Undriven line: pull-up gives 1, else the outside world's level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & (pullup_en | ext));
endmodule : plc_far_side_model
`default_nettype wire

// ===== plc_parallel_line_controller.sv
// What this block does
// R1 - Up to 32 lines, line n sits at bit n of every register.
// R2 - Pull-up enable write clears off bit, disable write sets it; 1 means off.
// R3 - Pull-up writes act whatever the line's ownership or direction.
// R4 - Reset enables all pull-ups, off status reads zero.
// R5 - Own set/clear writes set/clear ownership; 0 peripheral, 1 controller.
// R6 - Lines without peripheral ignore ownership writes and read 1.
// R7 - Ownership reset value is a per-line build parameter.
// R8 - Select A clears, select B sets choice bit; 1 means peripheral B.
// R9 - Choice steers only output path; both peripherals always see pin input.
// R10 - Reset clears every choice bit, selecting peripheral A.
// R11 - Software hands a pin over with a select write plus own-clear write.
// R12 - Peripheral-owned line driven by selected peripheral's value and enable.
// R13 - Drive set/clear writes set/clear drive enable; 1 means controller drives.
// R14 - Level set/clear writes set/clear the level driven on owned lines.
// R15 - Drive and level writes act even while a peripheral owns the line.
// R16 - Direct level write changes only bits whose write mask is 1.
// R17 - Mask set/clear writes set/clear the direct-write mask.
// R18 - Reset clears the direct-write mask.
// R19 - Config writes work ungated; pin readback and change detect need gate.
// R20 - Interrupt output asserts only while the controller clock is enabled.
// R21 - Zero bits change nothing; absent lines ignore writes, read zero.
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module plc_parallel_line_controller #(
    parameter int NUM_LINES = 32,
    parameter logic [31:0] MUXED_LINES = plc_pkg::DEF_MUXED,
    parameter logic [31:0] OWN_RESET = plc_pkg::DEF_OWN_RESET
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CTRL_CLK_EN,
    input wire logic [11:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [11:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic [31:0] PIN_IN,
    output logic [31:0] PIN_OUT,
    output logic [31:0] PIN_OE,
    output logic [31:0] PULLUP_EN,
    input wire logic [31:0] PERIPH_A_OUT,
    input wire logic [31:0] PERIPH_A_OE,
    input wire logic [31:0] PERIPH_B_OUT,
    input wire logic [31:0] PERIPH_B_OE,
    output logic [31:0] PERIPH_IN,
    output logic IRQ
);
    // ==========================================================
    // Types and state
    localparam logic [32:0] ONE33 = 33'h1_0000_0000 >> 32;
    localparam logic [31:0] IMPL = 32'((ONE33 << NUM_LINES) - ONE33); // [R1] [R21]
    localparam logic [31:0] MUXED = MUXED_LINES & IMPL;

    typedef enum logic [1:0] {WR_COLLECT = 2'b01, WR_RESP = 2'b10} plc_wr_t;
    typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_RESP = 2'b10} plc_rd_t;

    typedef struct packed {
        plc_wr_t wr;
        plc_rd_t rd;
        logic aw_got;
        logic w_got;
        logic [11:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [31:0] pullup_off;
        logic [31:0] own;
        logic [31:0] choice;
        logic [31:0] drive_en;
        logic [31:0] level;
        logic [31:0] wmask;
        logic [31:0] pin_s1;
        logic [31:0] pin_s2;
        logic [31:0] pin_s3;
        logic [31:0] pin_ok;
        logic [31:0] pin_level;
        logic [31:0] pin_out;
        logic [31:0] pin_oe;
        logic [31:0] pullup_en;
        logic irq;
    } plc_state_t;

    plc_state_t st;
    plc_state_t next_st;
    logic [31:0] lane;
    logic [31:0] wbits;
    logic [31:0] own_eff;
    logic [31:0] agree;
    logic [31:0] acc;

    // ==========================================================
    // Helpers
    // Byte strobes gate every set/clear word, so a narrow write touches only its lanes
    assign lane = IMPL & {{8{st.wstrb[3]}}, {8{st.wstrb[2]}}, {8{st.wstrb[1]}},
                          {8{st.wstrb[0]}}};
    assign wbits = st.wdata & lane; // [R21]
    assign own_eff = (st.own | ~MUXED) & IMPL; // [R6]
    // A change counts only once the second and third stages agree
    assign agree = ~(st.pin_s2 ^ st.pin_s3);
    assign acc = (st.pin_ok & ~agree) | (st.pin_s3 & agree);

    // ==========================================================
    // Next state
    always_comb begin
        next_st = st;
        if (AWVALID && st.awready) begin
            next_st.aw_got = 1'b1;
            next_st.waddr = AWADDR;
            next_st.awready = 1'b0;
        end
        if (WVALID && st.wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = WDATA;
            next_st.wstrb = WSTRB;
            next_st.wready = 1'b0;
        end
        case (st.wr)
            WR_COLLECT: begin
                if (st.aw_got && st.w_got) begin
                    next_st.bresp = plc_pkg::RESP_OKAY;
                    case (st.waddr)
                        plc_pkg::OFS_PU_EN: next_st.pullup_off = st.pullup_off & ~wbits; // [R2] [R3]
                        plc_pkg::OFS_PU_DIS: next_st.pullup_off = st.pullup_off | wbits; // [R2] [R3]
                        plc_pkg::OFS_OWN_SET: next_st.own = st.own | (wbits & MUXED); // [R5] [R6]
                        plc_pkg::OFS_OWN_CLR: next_st.own = st.own & ~(wbits & MUXED); // [R5] [R6]
                        plc_pkg::OFS_SEL_A: next_st.choice = st.choice & ~wbits; // [R8]
                        plc_pkg::OFS_SEL_B: next_st.choice = st.choice | wbits; // [R8]
                        plc_pkg::OFS_DRV_SET: next_st.drive_en = st.drive_en | wbits; // [R13] [R15]
                        plc_pkg::OFS_DRV_CLR: next_st.drive_en = st.drive_en & ~wbits; // [R13] [R15]
                        plc_pkg::OFS_LVL_SET: next_st.level = st.level | wbits; // [R14] [R15]
                        plc_pkg::OFS_LVL_CLR: next_st.level = st.level & ~wbits; // [R14] [R15]
                        plc_pkg::OFS_LVL_STAT: begin
                            next_st.level = (st.level & ~(st.wmask & lane))
                                          | (wbits & st.wmask); // [R16]
                        end
                        plc_pkg::OFS_WM_SET: next_st.wmask = st.wmask | wbits; // [R17]
                        plc_pkg::OFS_WM_CLR: next_st.wmask = st.wmask & ~wbits; // [R17]
                        default: next_st.bresp = plc_pkg::RESP_SLVERR;
                    endcase
                    next_st.bvalid = 1'b1;
                    next_st.aw_got = 1'b0;
                    next_st.w_got = 1'b0;
                    next_st.wr = WR_RESP;
                end
            end
            WR_RESP: begin
                if (BREADY) begin
                    next_st.bvalid = 1'b0;
                    next_st.awready = 1'b1;
                    next_st.wready = 1'b1;
                    next_st.wr = WR_COLLECT;
                end
            end
            default: next_st.wr = WR_COLLECT;
        endcase
        case (st.rd)
            RD_IDLE: begin
                if (ARVALID && st.arready) begin
                    next_st.arready = 1'b0;
                    next_st.rvalid = 1'b1;
                    next_st.rresp = plc_pkg::RESP_OKAY;
                    next_st.rd = RD_RESP;
                    case (ARADDR)
                        plc_pkg::OFS_OWN_STAT: next_st.rdata = own_eff; // [R6]
                        plc_pkg::OFS_DRV_STAT: next_st.rdata = st.drive_en;
                        plc_pkg::OFS_LVL_STAT: next_st.rdata = st.level;
                        plc_pkg::OFS_PIN_STAT: next_st.rdata = st.pin_level;
                        plc_pkg::OFS_PU_STAT: next_st.rdata = st.pullup_off;
                        plc_pkg::OFS_CHOICE_STAT: next_st.rdata = st.choice;
                        plc_pkg::OFS_WM_STAT: next_st.rdata = st.wmask;
                        default: begin
                            next_st.rdata = 32'h0000_0000;
                            next_st.rresp = plc_pkg::RESP_SLVERR;
                        end
                    endcase
                end
            end
            RD_RESP: begin
                if (RREADY) begin
                    next_st.rvalid = 1'b0;
                    next_st.arready = 1'b1;
                    next_st.rd = RD_IDLE;
                end
            end
            default: next_st.rd = RD_IDLE;
        endcase
        // Pins: three stages, first read only by the second
        next_st.pin_s1 = PIN_IN & IMPL;
        next_st.pin_s2 = st.pin_s1;
        next_st.pin_s3 = st.pin_s2;
        // Peripherals see the pin whatever the choice or the gate
        next_st.pin_ok = acc; // [R9]
        // Readback freezes and change detect is held low while the gate is off
        if (CTRL_CLK_EN) begin
            next_st.pin_level = acc; // [R19]
        end
        next_st.irq = CTRL_CLK_EN && ((acc ^ st.pin_level) != 32'h0000_0000); // [R20]
        // One register stage between the mux and the pins keeps outputs glitch free
        next_st.pin_out = IMPL & ((own_eff & st.level)
                        | (~own_eff & st.choice & PERIPH_B_OUT)
                        | (~own_eff & ~st.choice & PERIPH_A_OUT)); // [R12] [R14]
        next_st.pin_oe = IMPL & ((own_eff & st.drive_en)
                       | (~own_eff & st.choice & PERIPH_B_OE)
                       | (~own_eff & ~st.choice & PERIPH_A_OE)); // [R12] [R13]
        next_st.pullup_en = IMPL & ~st.pullup_off;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st <= '0;
            st.wr <= WR_COLLECT;
            st.rd <= RD_IDLE;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
            st.pullup_off <= plc_pkg::RST_PULLUP_OFF; // [R4]
            st.own <= OWN_RESET & IMPL; // [R7]
            st.choice <= plc_pkg::RST_CHOICE; // [R10]
            st.drive_en <= plc_pkg::RST_DRIVE;
            st.level <= plc_pkg::RST_LEVEL;
            st.wmask <= plc_pkg::RST_WMASK; // [R18]
            st.pullup_en <= IMPL;
        end else begin
            st <= next_st;
        end
    end

    assign AWREADY = st.awready;
    assign WREADY = st.wready;
    assign BRESP = st.bresp;
    assign BVALID = st.bvalid;
    assign ARREADY = st.arready;
    assign RDATA = st.rdata;
    assign RRESP = st.rresp;
    assign RVALID = st.rvalid;
    assign PIN_OUT = st.pin_out;
    assign PIN_OE = st.pin_oe;
    assign PULLUP_EN = st.pullup_en;
    assign PERIPH_IN = st.pin_ok;
    assign IRQ = st.irq;

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    sequence s_wr_done(logic [11:0] a);
        st.wr == WR_COLLECT && st.aw_got && st.w_got && st.waddr == a;
    endsequence

    a_pullup_enable: assert property ( // [R2]
        s_wr_done(plc_pkg::OFS_PU_EN) |=> (st.pullup_off & $past(wbits)) == 32'h0)
        else $error("pull-up enable write left off bit set");
    a_own_clear: assert property ( // [R5]
        s_wr_done(plc_pkg::OFS_OWN_CLR) |=> (own_eff & $past(wbits) & MUXED) == 32'h0)
        else $error("ownership clear write had no effect");
    a_unmuxed_own: assert property ( // [R6]
        (own_eff & ~MUXED & IMPL) == (~MUXED & IMPL))
        else $error("line without peripheral not controller owned");
    a_choice_b: assert property ( // [R8]
        s_wr_done(plc_pkg::OFS_SEL_B) |=> (st.choice & $past(wbits)) == $past(wbits))
        else $error("select B write did not set choice");
    a_level_set: assert property ( // [R14]
        s_wr_done(plc_pkg::OFS_LVL_SET) |=> (st.level & $past(wbits)) == $past(wbits))
        else $error("level set write did not set level");
    a_direct_mask: assert property ( // [R16]
        s_wr_done(plc_pkg::OFS_LVL_STAT) |=> ((st.level ^ $past(st.level)) & ~$past(st.wmask)) == 32'h0)
        else $error("direct write changed a masked bit");
    a_ctrl_drive: assert property ( // [R13]
        1'b1 |=> (PIN_OE & $past(own_eff)) == ($past(st.drive_en) & $past(own_eff)))
        else $error("owned line enable differs from drive status");
    a_periph_drive: assert property ( // [R12]
        1'b1 |=> (PIN_OUT & ~$past(own_eff) & $past(st.choice))
            == ($past(PERIPH_B_OUT) & ~$past(own_eff) & $past(st.choice) & IMPL))
        else $error("peripheral B output not routed to pin");
    a_gate_freeze: assert property ( // [R19]
        !CTRL_CLK_EN |=> $stable(st.pin_level))
        else $error("pin readback moved with gate off");
    a_irq_gate: assert property ( // [R20]
        IRQ |-> $past(CTRL_CLK_EN))
        else $error("interrupt raised with gate off");
    a_bresp_hold: assert property (
        BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped before taken");
    a_rdata_hold: assert property (
        RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data changed before taken");
endmodule : plc_parallel_line_controller
`default_nettype wire

// ===== plc_pkg.sv
`default_nettype none
// ==========================================================
// Register map
package plc_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_OWN_SET = 12'h000;
    localparam logic [11:0] OFS_OWN_CLR = 12'h004;
    localparam logic [11:0] OFS_OWN_STAT = 12'h008;
    localparam logic [11:0] OFS_DRV_SET = 12'h010;
    localparam logic [11:0] OFS_DRV_CLR = 12'h014;
    localparam logic [11:0] OFS_DRV_STAT = 12'h018;
    localparam logic [11:0] OFS_LVL_SET = 12'h030;
    localparam logic [11:0] OFS_LVL_CLR = 12'h034;
    localparam logic [11:0] OFS_LVL_STAT = 12'h038;
    localparam logic [11:0] OFS_PIN_STAT = 12'h03c;
    localparam logic [11:0] OFS_PU_EN = 12'h060;
    localparam logic [11:0] OFS_PU_DIS = 12'h064;
    localparam logic [11:0] OFS_PU_STAT = 12'h068;
    localparam logic [11:0] OFS_SEL_A = 12'h070;
    localparam logic [11:0] OFS_SEL_B = 12'h074;
    localparam logic [11:0] OFS_CHOICE_STAT = 12'h078;
    localparam logic [11:0] OFS_WM_SET = 12'h0a0;
    localparam logic [11:0] OFS_WM_CLR = 12'h0a4;
    localparam logic [11:0] OFS_WM_STAT = 12'h0a8;
    // ==========================================================
    // Reset values
    localparam logic [31:0] RST_PULLUP_OFF = 32'h0000_0000;
    localparam logic [31:0] RST_CHOICE = 32'h0000_0000;
    localparam logic [31:0] RST_DRIVE = 32'h0000_0000;
    localparam logic [31:0] RST_LEVEL = 32'h0000_0000;
    localparam logic [31:0] RST_WMASK = 32'h0000_0000;
    localparam logic [31:0] DEF_OWN_RESET = 32'hffff_ffff;
    localparam logic [31:0] DEF_MUXED = 32'hffff_ffff;
    // ==========================================================
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : plc_pkg
`default_nettype wire

// ===== tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam logic [31:0] IMPL = 32'h3fff_ffff;
    localparam logic [31:0] MUX = 32'h3fff_fff7;
    localparam logic [31:0] ORST = 32'hfffe_ffff;
    localparam logic [11:0] SET_OFS [6] = '{plc_pkg::OFS_OWN_SET, plc_pkg::OFS_DRV_SET,
        plc_pkg::OFS_LVL_SET, plc_pkg::OFS_PU_DIS, plc_pkg::OFS_SEL_B, plc_pkg::OFS_WM_SET};
    localparam logic [11:0] CLR_OFS [6] = '{plc_pkg::OFS_OWN_CLR, plc_pkg::OFS_DRV_CLR,
        plc_pkg::OFS_LVL_CLR, plc_pkg::OFS_PU_EN, plc_pkg::OFS_SEL_A, plc_pkg::OFS_WM_CLR};
    localparam logic [11:0] ST_OFS [6] = '{plc_pkg::OFS_OWN_STAT, plc_pkg::OFS_DRV_STAT,
        plc_pkg::OFS_LVL_STAT, plc_pkg::OFS_PU_STAT, plc_pkg::OFS_CHOICE_STAT, plc_pkg::OFS_WM_STAT};
    logic clk = 1'b0, rst_n = 1'b0, gate = 1'b0, shuffle = 1'b0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    wire logic awready, wready, bvalid, arready, rvalid;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata, pin_in, pin_out, pin_oe, pu_en, a_out, a_oe, b_out, b_oe, p_in;
    int mismatches = 0, check_count = 0;
    logic [31:0] mdl [6];
    always #50 clk = ~clk;
    plc_parallel_line_controller #(.NUM_LINES(30), .MUXED_LINES(MUX), .OWN_RESET(ORST)) u_dut (
        .CLK(clk), .RST_N(rst_n), .CTRL_CLK_EN(gate), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PULLUP_EN(pu_en),
        .PERIPH_A_OUT(a_out), .PERIPH_A_OE(a_oe), .PERIPH_B_OUT(b_out), .PERIPH_B_OE(b_oe),
        .PERIPH_IN(p_in), .IRQ());
    plc_far_side_model u_far (.clk(clk), .shuffle(shuffle), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pu_en), .pin_in(pin_in), .a_out(a_out), .a_oe(a_oe), .b_out(b_out),
        .b_oe(b_oe));
    // ==========================================================
    // Comparison and bus tasks
    task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk32
    task automatic chk2(input string what, input logic [1:0] exp, input logic [1:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk2
    // Outputs are registered, so values read right after the edge are the sampled ones
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_busy, w_busy;
        int n;
        aw_busy = 1'b1;
        w_busy = 1'b1;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (aw_busy && awready === 1'b1) begin
                aw_busy = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_busy && wready === 1'b1) begin
                w_busy = 1'b0;
                wvalid <= 1'b0;
            end
        end while ((aw_busy || w_busy || bvalid !== 1'b1) && n < 100);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_busy;
        int n;
        ar_busy = 1'b1;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (ar_busy && arready === 1'b1) begin
                ar_busy = 1'b0;
                arvalid <= 1'b0;
            end
        end while ((ar_busy || rvalid !== 1'b1) && n < 100);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd
    task automatic wr_ok(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        chk2("bresp", plc_pkg::RESP_OKAY, r);
    endtask : wr_ok
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk32(what, exp, d);
        chk2("rresp", plc_pkg::RESP_OKAY, r);
    endtask : rd_chk
    task automatic pins_chk();
        logic [31:0] o, c;
        shuffle <= 1'b1;
        @(posedge clk);
        shuffle <= 1'b0;
        repeat (6) @(posedge clk);
        o = mdl[0];
        c = mdl[4];
        chk32("pin_oe", IMPL & ((o & mdl[1]) | (~o & c & b_oe) | (~o & ~c & a_oe)),
            pin_oe & IMPL);
        chk32("pin_out", IMPL & ((o & mdl[2]) | (~o & c & b_out) | (~o & ~c & a_out)),
            pin_out & IMPL);
        chk32("pullup_en", ~mdl[3] & IMPL, pu_en);
        chk32("periph_in", pin_in & IMPL, p_in & IMPL);
    endtask : pins_chk
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        void'($urandom(32'h7372ef64));
        mdl = '{(ORST | ~MUX) & IMPL, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int k = 0; k < 6; k++) rd_chk("reset status", ST_OFS[k], mdl[k]);
        pins_chk();
        // First round runs with the gate off: configuration must still land
        for (int i = 0; i < 4; i++) begin
            gate <= (i > 0);
            for (int k = 0; k < 6; k++) begin
                d = $urandom();
                wr_ok(SET_OFS[k], d);
                mdl[k] = (mdl[k] | d | ((k == 0) ? ~MUX : 32'h0)) & IMPL;
                rd_chk("after set", ST_OFS[k], mdl[k]);
                d = $urandom();
                wr_ok(CLR_OFS[k], d);
                mdl[k] = ((mdl[k] & ~d) | ((k == 0) ? ~MUX : 32'h0)) & IMPL;
                rd_chk("after clear", ST_OFS[k], mdl[k]);
            end
            d = $urandom();
            wr_ok(plc_pkg::OFS_LVL_STAT, d);
            mdl[2] = ((mdl[2] & ~mdl[5]) | (d & mdl[5])) & IMPL;
            rd_chk("direct level", plc_pkg::OFS_LVL_STAT, mdl[2]);
            pins_chk();
            if (i > 0) rd_chk("pin level", plc_pkg::OFS_PIN_STAT, pin_in & IMPL);
        end
        wr_ok(plc_pkg::OFS_SEL_B, 32'h0000_0001);
        wr_ok(plc_pkg::OFS_OWN_CLR, 32'h0000_0001);
        mdl[4] = mdl[4] | 32'h0000_0001;
        mdl[0] = mdl[0] & ~32'h0000_0001;
        pins_chk();
        axi_wr(plc_pkg::OFS_OWN_STAT, 32'h0, r);
        chk2("read-only write", plc_pkg::RESP_SLVERR, r);
        rd_chk("owner kept", plc_pkg::OFS_OWN_STAT, mdl[0]);
        axi_rd(plc_pkg::OFS_OWN_SET, d, r);
        chk2("write-only read", plc_pkg::RESP_SLVERR, r);
        axi_rd(12'h0fc, d, r);
        chk2("unmapped read", plc_pkg::RESP_SLVERR, r);
        chk32("unmapped data", 32'h0, d);
        complete_run();
    end
    initial begin
        #(20000 * 100);
        mismatches++;
        complete_run();
    end
endmodule : tb
`default_nettype wire
